/* include/pfc_pkg.sv */
// Behaviour
// - Read: host holds select and output gate low, write strobe high; device drives byte.
// - Write cycles: host drives write strobe and select low, output gate high.
// - In bypass mode a byte program takes two write cycles instead of four.
// - Host keeps fast-program pin off boost voltage except during accelerated program.
`default_nettype none
package pfc_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 40;
   // Access times in ns, converted to cycles rounding up
   localparam int READ_ACCESS_NS = 70;
   localparam int SELECT_ACCESS_NS = 70;
   localparam int AUTO_STANDBY_EXTRA_NS = 30;
   localparam int WRITE_PULSE_NS = 35;
   localparam int RESET_PULSE_NS = 500;
   localparam int ACCESS_CYC = (SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IDLE_LOWPOWER_CYC =
      (READ_ACCESS_NS + AUTO_STANDBY_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Address bit positions
   localparam int BIT_ZERO = 0;
   localparam int BIT_ONE = 1;
   localparam int BIT_SIX = 6;
   localparam int BIT_NINE = 9;
   localparam int SECTOR_LSB = 16;
   // Unlock addresses and data, command words and protect status codes
   localparam logic [11:0] UNLOCK_ADDR1 = 12'haaa;
   localparam logic [11:0] UNLOCK_ADDR2 = 12'h555;
   localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
   localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CMD_AUTOSELECT = 8'h90;
   localparam logic [7:0] CMD_BYPASS_ENTER = 8'h20;
   localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
   localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
   localparam logic [7:0] CMD_RESET = 8'hf0;
   localparam logic [7:0] PROTECTED_CODE = 8'h01;
   localparam logic [7:0] UNPROTECTED_CODE = 8'h00;

   typedef enum logic [3:0]
   {
      OP_READ = 4'h0,
      OP_PROGRAM = 4'h1,
      OP_BYPASS_PROGRAM = 4'h2,
      OP_SECTOR_ERASE = 4'h3,
      OP_CHIP_ERASE = 4'h4,
      OP_AUTOSELECT = 4'h5,
      OP_BYPASS_ENTER = 4'h6,
      OP_BYPASS_EXIT = 4'h7,
      OP_READ_RESET = 4'h8,
      OP_GROUP_PROTECT = 4'h9,
      OP_CHIP_UNPROTECT = 4'ha,
      OP_HW_RESET = 4'hb,
      OP_RAW_WRITE = 4'hc
   } pfc_op_t;

   // Request from the user side
   typedef struct packed
   {
      pfc_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic hv_nine; // Address bit nine at high voltage during reads
   } pfc_req_t;

   // Pins toward the flash
   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic chip_select_n;
      logic output_gate_n;
      logic write_strobe_n;
      logic reset_n;
      logic reset_hv; // Reset pin driven to high_voltage_level
      logic nine_hv; // Address bit nine driven to high_voltage_level
      logic fast_program_pin; // Boost voltage requested
   } pfc_pins_t;
endpackage
`default_nettype wire

/* hdl/pfc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module pfc_host
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic req_valid,
   output logic req_ready,
   input wire pfc_pkg::pfc_req_t req,
   output logic rsp_valid,
   output logic [pfc_pkg::DATA_W-1:0] rsp_data,
   output pfc_pkg::pfc_pins_t pins,
   output logic [pfc_pkg::DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic [pfc_pkg::DATA_W-1:0] data_in,
   output logic low_power_hint
);
   typedef enum logic [5:0]
   {
      ST_IDLE = 6'h01,
      ST_READ = 6'h02,
      ST_WSETUP = 6'h04,
      ST_WPULSE = 6'h08,
      ST_WHOLD = 6'h10,
      ST_RESET = 6'h20
   } pfc_state_t;

   localparam int SEQ_MAX = 6;
   localparam int CNT_W = 8;

   pfc_state_t state;
   logic [CNT_W-1:0] cnt;
   logic [2:0] step;
   logic [2:0] steps;
   pfc_pkg::pfc_req_t cur;
   logic [pfc_pkg::ADDR_W-1:0] seq_addr [SEQ_MAX];
   logic [pfc_pkg::DATA_W-1:0] seq_data [SEQ_MAX];
   logic [pfc_pkg::DATA_W-1:0] d_s1;
   logic [pfc_pkg::DATA_W-1:0] d_s2;
   logic [CNT_W-1:0] idle_cnt;
   logic last_step;

   // Widen a 12-bit unlock address to the bus
   function automatic logic [pfc_pkg::ADDR_W-1:0] ua(input logic [11:0] a);
      ua = {{(pfc_pkg::ADDR_W-12){1'b0}}, a};
   endfunction

   // Build the write sequence for an operation
   always_comb
   begin
      for (int i = 0; i < SEQ_MAX; i++)
      begin
         seq_addr[i] = cur.addr;
         seq_data[i] = cur.data;
      end
      seq_addr[0] = ua(pfc_pkg::UNLOCK_ADDR1);
      seq_data[0] = pfc_pkg::UNLOCK_DATA1;
      seq_addr[1] = ua(pfc_pkg::UNLOCK_ADDR2);
      seq_data[1] = pfc_pkg::UNLOCK_DATA2;
      seq_addr[2] = ua(pfc_pkg::UNLOCK_ADDR1);
      seq_data[2] = pfc_pkg::CMD_ERASE_SETUP;
      seq_addr[3] = ua(pfc_pkg::UNLOCK_ADDR1);
      seq_data[3] = pfc_pkg::UNLOCK_DATA1;
      seq_addr[4] = ua(pfc_pkg::UNLOCK_ADDR2);
      seq_data[4] = pfc_pkg::UNLOCK_DATA2;
      steps = 3'd3;
      case (cur.op)
         pfc_pkg::OP_PROGRAM:
         begin
            seq_data[2] = pfc_pkg::CMD_PROGRAM; // Four cycles, last is the byte
            seq_addr[3] = cur.addr;
            seq_data[3] = cur.data;
            steps = 3'd4;
         end
         pfc_pkg::OP_BYPASS_PROGRAM:
         begin
            seq_addr[0] = cur.addr;
            seq_data[0] = pfc_pkg::CMD_PROGRAM; // Only two cycles in bypass
            seq_addr[1] = cur.addr;
            seq_data[1] = cur.data;
            steps = 3'd2;
         end
         pfc_pkg::OP_SECTOR_ERASE:
         begin
            seq_data[5] = pfc_pkg::CMD_SECTOR_ERASE; // Sector picked by upper bits
            steps = 3'd6;
         end
         pfc_pkg::OP_CHIP_ERASE:
         begin
            seq_addr[5] = ua(pfc_pkg::UNLOCK_ADDR1);
            seq_data[5] = pfc_pkg::CMD_CHIP_ERASE; // Whole device
            steps = 3'd6;
         end
         pfc_pkg::OP_AUTOSELECT: seq_data[2] = pfc_pkg::CMD_AUTOSELECT;
         pfc_pkg::OP_BYPASS_ENTER: seq_data[2] = pfc_pkg::CMD_BYPASS_ENTER;
         pfc_pkg::OP_BYPASS_EXIT:
         begin
            seq_data[0] = pfc_pkg::CMD_BYPASS_EXIT1;
            seq_data[1] = pfc_pkg::CMD_BYPASS_EXIT2;
            steps = 3'd2;
         end
         pfc_pkg::OP_READ_RESET:
         begin
            seq_data[0] = pfc_pkg::CMD_RESET; // Aborts any sequence back to array read
            steps = 3'd1;
         end
         pfc_pkg::OP_GROUP_PROTECT, pfc_pkg::OP_CHIP_UNPROTECT, pfc_pkg::OP_RAW_WRITE:
         begin
            seq_addr[0] = cur.addr;
            seq_data[0] = cur.data;
            seq_addr[0][pfc_pkg::BIT_ONE] = cur.op != pfc_pkg::OP_RAW_WRITE
               ? 1'b1 : cur.addr[pfc_pkg::BIT_ONE];
            if (cur.op != pfc_pkg::OP_RAW_WRITE)
            begin
               seq_addr[0][pfc_pkg::BIT_ZERO] = 1'b0;
               seq_addr[0][pfc_pkg::BIT_SIX] = cur.op == pfc_pkg::OP_CHIP_UNPROTECT;
            end
            steps = 3'd1;
         end
         default: steps = 3'd1;
      endcase
   end

   assign last_step = step == steps - 3'd1;
   assign req_ready = state == ST_IDLE;

   // Data pins are asynchronous to this clock
   always_ff @(posedge clock)
   begin
      d_s1 <= data_in;
      d_s2 <= d_s1;
   end

   // Main cycle sequencer
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         cnt <= '0;
         step <= '0;
         cur <= '0;
      end
      else
      begin
         case (state)
            ST_IDLE:
               if (req_valid)
               begin
                  cur <= req;
                  step <= '0;
                  cnt <= '0;
                  if (req.op == pfc_pkg::OP_READ)
                     state <= ST_READ;
                  else if (req.op == pfc_pkg::OP_HW_RESET)
                     state <= ST_RESET;
                  else
                     state <= ST_WSETUP;
               end
            ST_READ:
            begin
               // Two extra cycles cover the data synchroniser
               cnt <= cnt + 8'h01;
               if (cnt == CNT_W'(pfc_pkg::ACCESS_CYC + 2))
                  state <= ST_IDLE;
            end
            ST_WSETUP:
               state <= ST_WPULSE;
            ST_WPULSE:
            begin
               cnt <= cnt + 8'h01;
               if (cnt == CNT_W'(pfc_pkg::WRITE_CYC - 1))
               begin
                  cnt <= '0;
                  state <= ST_WHOLD;
               end
            end
            ST_WHOLD:
               if (last_step)
                  state <= ST_IDLE;
               else
               begin
                  step <= step + 3'd1;
                  state <= ST_WSETUP;
               end
            ST_RESET:
            begin
               // Reset pulse; no recovery wait on release
               cnt <= cnt + 8'h01;
               if (cnt == CNT_W'(pfc_pkg::RESET_CYC - 1))
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Read answer
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         rsp_valid <= 1'b0;
         rsp_data <= '0;
      end
      else
      begin
         rsp_valid <= state == ST_READ && cnt == CNT_W'(pfc_pkg::ACCESS_CYC + 2);
         if (state == ST_READ && cnt == CNT_W'(pfc_pkg::ACCESS_CYC + 2))
            rsp_data <= d_s2; // Array, ID or protect code
      end
   end

   // Pin drive; select released between cycles, stays off when idle
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pins <= '0;
         pins.chip_select_n <= 1'b1;
         pins.output_gate_n <= 1'b1;
         pins.write_strobe_n <= 1'b1;
         pins.reset_n <= 1'b1;
         data_out <= '0;
         data_oe <= 1'b0;
      end
      else
      begin
         pins.reset_n <= !(state == ST_IDLE && req_valid && req.op == pfc_pkg::OP_HW_RESET)
            && !(state == ST_RESET && cnt != CNT_W'(pfc_pkg::RESET_CYC - 1));
         // Released on the answer edge, so the device is in standby whenever ready is high
         pins.chip_select_n <= !((state == ST_READ && cnt != CNT_W'(pfc_pkg::ACCESS_CYC + 2))
            || state == ST_WSETUP || state == ST_WPULSE
            || (state == ST_IDLE && req_valid && req.op == pfc_pkg::OP_READ));
         pins.output_gate_n <= !((state == ST_READ && cnt != CNT_W'(pfc_pkg::ACCESS_CYC + 2))
            || (state == ST_IDLE && req_valid && req.op == pfc_pkg::OP_READ));
         pins.write_strobe_n <= !(state == ST_WSETUP
            || (state == ST_WPULSE && cnt != CNT_W'(pfc_pkg::WRITE_CYC - 1)));
         if (state == ST_IDLE && req_valid)
         begin
            pins.addr <= req.addr;
            pins.nine_hv <= req.op == pfc_pkg::OP_READ && req.hv_nine;
         end
         else if (state == ST_WHOLD && !last_step)
            pins.addr <= seq_addr[step + 3'd1];
         else if (state == ST_IDLE)
            pins.nine_hv <= 1'b0;
         if (state == ST_IDLE && req_valid && req.op != pfc_pkg::OP_READ)
            pins.addr <= (req.op == pfc_pkg::OP_BYPASS_PROGRAM
               || req.op >= pfc_pkg::OP_GROUP_PROTECT) ? req.addr
               : ua(pfc_pkg::UNLOCK_ADDR1);
         if (state == ST_WSETUP)
            pins.addr <= seq_addr[step];
         // High voltage on reset only for protect writes
         pins.reset_hv <= state != ST_IDLE
            && (cur.op == pfc_pkg::OP_GROUP_PROTECT || cur.op == pfc_pkg::OP_CHIP_UNPROTECT);
         // Boost only around bypass programming
         pins.fast_program_pin <= state != ST_IDLE && state != ST_READ
            && cur.op == pfc_pkg::OP_BYPASS_PROGRAM;
         data_out <= seq_data[step];
         data_oe <= state == ST_WSETUP || state == ST_WPULSE; // Never while gate low
      end
   end

   // Stable address lets the device sleep; host reports it
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         idle_cnt <= '0;
         low_power_hint <= 1'b0;
      end
      else if (state != ST_IDLE)
      begin
         idle_cnt <= '0;
         low_power_hint <= 1'b0;
      end
      else if (idle_cnt != CNT_W'(pfc_pkg::IDLE_LOWPOWER_CYC))
         idle_cnt <= idle_cnt + 8'h01;
      else
         low_power_hint <= 1'b1;
   end
endmodule
`default_nettype wire

/* test/pfc_host_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module pfc_host_chk
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire pfc_pkg::pfc_req_t req,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire pfc_pkg::pfc_pins_t pins,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic [7:0] data_in,
   input wire logic low_power_hint
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   property p_read;
      !pins.output_gate_n |-> !pins.chip_select_n && pins.write_strobe_n;
   endproperty
   a_read: assert property (p_read) else $error("bad read pins");
   property p_write;
      !pins.write_strobe_n |-> !pins.chip_select_n && pins.output_gate_n && data_oe;
   endproperty
   a_write: assert property (p_write) else $error("bad write pins");
   property p_bus;
      data_oe |-> pins.output_gate_n;
   endproperty
   a_bus: assert property (p_bus) else $error("data fight");
   property p_lat;
      req_valid && req_ready && req.op == pfc_pkg::OP_READ |-> !rsp_valid [*6] ##1 rsp_valid;
   endproperty
   a_lat: assert property (p_lat) else $error("read answer late");
   property p_pulse;
      rsp_valid |=> !rsp_valid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("answer too long");
   property p_boost;
      pins.fast_program_pin |-> pins.output_gate_n && !pins.reset_hv;
   endproperty
   a_boost: assert property (p_boost) else $error("boost misuse");
   property p_prot;
      pins.reset_hv && !pins.write_strobe_n |-> pins.addr[1] && !pins.addr[0];
   endproperty
   a_prot: assert property (p_prot) else $error("bad protect addr");
   property p_hwrst;
      $fell(pins.reset_n) |=> !pins.reset_n [*8];
   endproperty
   a_hwrst: assert property (p_hwrst) else $error("reset pulse short");
   property p_idle;
      req_ready |-> pins.chip_select_n && !data_oe && pins.reset_n;
   endproperty
   a_idle: assert property (p_idle) else $error("idle not standby");
endmodule
bind pfc_host pfc_host_chk chk_u (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
   .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
   .pins(pins), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
   .low_power_hint(low_power_hint));
`default_nettype wire

/* test/pfc_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pfc_flash_model
#(
   parameter logic [7:0] MFG_CODE = 8'h5e, // Arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h7b // Arbitrary value
)
(
   input wire pfc_pkg::pfc_pins_t pins,
   input wire logic [7:0] data_out,
   output logic [7:0] data_in
);
   logic [7:0] mem [int];
   logic prot [64] = '{default: 1'b0};
   int step = 0;
   int mode = 0; // 1 auto-select, 2 program data next
   logic byp = 1'b0;
   logic [7:0] q;
   logic [7:0] last = 8'h00;
   wire logic drive = pins.reset_n && !pins.chip_select_n && !pins.output_gate_n
      && pins.write_strobe_n;

   function automatic logic [7:0] val(input int a);
      return mem.exists(a) ? mem[a] : 8'hff;
   endfunction

   task automatic idle();
      step = 0;
      mode = 0;
   endtask

   // Released lines flip, so a stale byte is never read as good
   assign data_in = drive ? q : ~last;
   always @*
      if (drive)
         last = q;

   // Codes on high voltage or in auto-select, else the array
   always @(pins or mode)
      if (pins.nine_hv || mode == 1)
         q = pins.addr[1] ? {7'h00, prot[pins.addr[21:16]]} :
            (pins.addr[0] ? DEV_CODE : MFG_CODE);
      else
         q = val(pins.addr);

   // Reset low aborts everything
   always @(negedge pins.reset_n)
   begin
      idle();
      byp = 1'b0;
   end

   // Commands latch on the rising write strobe; algorithms end at once
   always @(posedge pins.write_strobe_n)
      if (pins.reset_n && !pins.chip_select_n && pins.output_gate_n)
         cyc(pins.addr, data_out);

   // Sector erase takes one sector per command, chip erase takes all unprotected sectors; protection is per sector
   task automatic cyc(input logic [21:0] a, input logic [7:0] d);
      logic u1;
      logic u2;
      u1 = a[11:0] == pfc_pkg::UNLOCK_ADDR1 && d == pfc_pkg::UNLOCK_DATA1;
      u2 = a[11:0] == pfc_pkg::UNLOCK_ADDR2 && d == pfc_pkg::UNLOCK_DATA2;
      if (pins.reset_hv && a[1] && !a[0])
         foreach (prot[i])
            prot[i] = !a[6] && (prot[i] || i == int'(a[21:16]));
      else if (mode == 2)
      begin
         if (!prot[a[21:16]] || pins.reset_hv || pins.fast_program_pin)
            mem[a] = val(a) & d;
         idle();
      end
      else if (byp || pins.fast_program_pin)
      begin
         byp = !(step == 1 && d == pfc_pkg::CMD_BYPASS_EXIT2);
         step = int'(d == pfc_pkg::CMD_BYPASS_EXIT1);
         mode = d == pfc_pkg::CMD_PROGRAM ? 2 : 0;
      end
      else if ((u1 && step % 3 == 0) || (u2 && step % 3 == 1))
         step++;
      else if (step == 2)
      begin
         mode = d == pfc_pkg::CMD_AUTOSELECT ? 1 : (d == pfc_pkg::CMD_PROGRAM ? 2 : 0);
         byp = d == pfc_pkg::CMD_BYPASS_ENTER;
         step = d == pfc_pkg::CMD_ERASE_SETUP ? 3 : 0;
      end
      else if (step == 5)
      begin
         foreach (mem[k])
            if ((d == pfc_pkg::CMD_CHIP_ERASE || k[21:16] == a[21:16])
               && (!prot[k[21:16]] || pins.reset_hv))
               mem[k] = 8'hff;
         idle();
      end
      else
         idle();
   endtask
endmodule
`default_nettype wire

/* test/pfc_host_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module pfc_host_tb;
   localparam logic [7:0] MFG = 8'h5e; // Arbitrary value
   localparam logic [7:0] DEV = 8'h7b; // Arbitrary value
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   pfc_pkg::pfc_req_t req = '0;
   logic req_ready, rsp_valid, data_oe, low_power_hint;
   logic [7:0] rsp_data, data_out, data_in, q;
   pfc_pkg::pfc_pins_t pins;
   int failures = 0;
   int total_checks = 0;

   always #20 clock = ~clock;

   pfc_host dut_u (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .data_out(data_out),
      .data_oe(data_oe), .data_in(data_in), .low_power_hint(low_power_hint));
   pfc_flash_model #(.MFG_CODE(MFG), .DEV_CODE(DEV)) flash_u (.pins(pins),
      .data_out(data_out), .data_in(data_in));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One request; counts write strobes and the read answer delay
   task automatic run(input pfc_pkg::pfc_op_t op, input logic [21:0] a, input logic [7:0] d,
      input logic hv, input logic [7:0] n_we);
      logic [7:0] w;
      logic [7:0] lat;
      logic we_d;
      int k;
      w = 8'h00;
      lat = 8'h00;
      we_d = 1'b1;
      check(req_ready, 8'h01);
      @(posedge clock);
      req_valid <= 1'b1;
      req <= '{op, a, d, hv};
      @(posedge clock);
      req_valid <= 1'b0;
      for (k = 1; k <= 200; k++)
      begin
         @(negedge clock);
         if (rsp_valid === 1'b1)
            lat = 8'(k);
         if (rsp_valid === 1'b1)
            q = rsp_data;
         if (we_d && pins.write_strobe_n === 1'b0)
            w++;
         we_d = pins.write_strobe_n;
         if (req_ready === 1'b1)
            break;
      end
      failures += int'(k > 200);
      if (k > 200)
         wrap_up();
      check(w, n_we);
      check(lat, op == pfc_pkg::OP_READ ? 8'h06 : 8'h00);
   endtask

   task automatic rd(input logic [21:0] a, input logic hv, input logic [7:0] exp);
      run(pfc_pkg::OP_READ, a, 8'h00, hv, 8'h00);
      check(q, exp);
   endtask

   task automatic wr(input logic [21:0] a, input logic [7:0] d);
      run(pfc_pkg::OP_RAW_WRITE, a, d, 1'b0, 8'h01);
   endtask

   task automatic t_program();
      rd(22'h012345, 1'b0, 8'hff);
      repeat (6) @(negedge clock);
      check(low_power_hint, 8'h01);
      run(pfc_pkg::OP_PROGRAM, 22'h012345, 8'h5a, 1'b0, 8'h04);
      check(low_power_hint, 8'h00);
      rd(22'h012345, 1'b0, 8'h5a);
      rd(22'h012345, 1'b0, 8'h5a);
   endtask

   // Bypass program then both erase kinds
   task automatic t_bypass_erase();
      run(pfc_pkg::OP_BYPASS_ENTER, 22'h0, 8'h00, 1'b0, 8'h03);
      run(pfc_pkg::OP_BYPASS_PROGRAM, 22'h020010, 8'h3c, 1'b0, 8'h02);
      run(pfc_pkg::OP_BYPASS_EXIT, 22'h0, 8'h00, 1'b0, 8'h02);
      rd(22'h020010, 1'b0, 8'h3c);
      run(pfc_pkg::OP_SECTOR_ERASE, 22'h010000, 8'h00, 1'b0, 8'h06);
      rd(22'h012345, 1'b0, 8'hff);
      rd(22'h020010, 1'b0, 8'h3c);
      run(pfc_pkg::OP_CHIP_ERASE, 22'h0, 8'h00, 1'b0, 8'h06);
      rd(22'h020010, 1'b0, 8'hff);
   endtask

   // Identity codes by high voltage and by command, protect and unprotect
   task automatic t_ids_protect();
      rd(22'h000000, 1'b1, MFG);
      rd(22'h000001, 1'b1, DEV);
      run(pfc_pkg::OP_AUTOSELECT, 22'h0, 8'h00, 1'b0, 8'h03);
      rd(22'h000001, 1'b0, DEV);
      run(pfc_pkg::OP_READ_RESET, 22'h0, 8'h00, 1'b0, 8'h01);
      rd(22'h000001, 1'b0, 8'hff);
      run(pfc_pkg::OP_GROUP_PROTECT, 22'h030002, 8'h00, 1'b0, 8'h01);
      rd(22'h030002, 1'b1, 8'h01);
      rd(22'h020002, 1'b1, 8'h00);
      run(pfc_pkg::OP_PROGRAM, 22'h030100, 8'h00, 1'b0, 8'h04);
      rd(22'h030100, 1'b0, 8'hff);
      run(pfc_pkg::OP_CHIP_UNPROTECT, 22'h000042, 8'h00, 1'b0, 8'h01);
      rd(22'h030002, 1'b1, 8'h00);
   endtask

   // Broken sequence, then hardware reset out of auto-select
   task automatic t_abort();
      wr(22'h000aaa, 8'haa);
      wr(22'h000123, 8'h77);
      wr(22'h000aaa, 8'h90);
      rd(22'h000001, 1'b0, 8'hff);
      wr(22'h000aaa, 8'haa);
      wr(22'h000555, 8'h55);
      wr(22'h000aaa, 8'h90);
      rd(22'h000001, 1'b0, DEV);
      run(pfc_pkg::OP_HW_RESET, 22'h0, 8'h00, 1'b0, 8'h00);
      rd(22'h000001, 1'b0, 8'hff);
   endtask

   initial
   begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      t_program();
      t_bypass_erase();
      t_ids_protect();
      t_abort();
      wrap_up();
   end
endmodule
`default_nettype wire
